// [rtl/sound_pwm_pkg.sv]
// Shared constants for the sound amplitude PWM and reload-flag block.
// Assumes a 32-bit AHB-Lite register bus; registers sit one per word.
package sound_pwm_pkg;

  // Data widths
  localparam int unsigned LEVEL_W = 11;
  localparam int unsigned COUNT_W = 8;
  localparam int unsigned REG_W = 8;
  localparam int unsigned IDX_W = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h00;
  localparam logic [IDX_W-1:0] IDX_PRESCALE_HIGH = 6'h02;
  localparam logic [IDX_W-1:0] IDX_PRESCALE_LOW = 6'h03;
  localparam logic [IDX_W-1:0] IDX_AMPLITUDE_HIGH = 6'h06;
  localparam logic [IDX_W-1:0] IDX_AMPLITUDE_LOW = 6'h07;
  localparam logic [IDX_W-1:0] IDX_DURATION_LENGTH = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAG = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_WORKING_HIGH = 6'h10;
  localparam logic [IDX_W-1:0] IDX_WORKING_LOW = 6'h11;
  localparam logic [IDX_W-1:0] IDX_DURATION_COUNT = 6'h12;

  // Field positions
  localparam int unsigned CTRL_RELOAD_REQUEST = 0;
  localparam int unsigned CTRL_ENABLE = 1;
  localparam int unsigned CTRL_STOP = 2;
  localparam int unsigned NEXT_DATA_BIT = 0;
  localparam int unsigned HIGH_PART_W = LEVEL_W - REG_W;

  // Values after reset
  localparam logic [REG_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [LEVEL_W-1:0] PRESCALE_RESET = 11'h0FF;
  localparam logic [LEVEL_W-1:0] AMPLITUDE_RESET = 11'h000;
  localparam logic [COUNT_W-1:0] DURATION_RESET = 8'h00;
  localparam logic [REG_W-1:0] IRQ_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Sequencer states
  typedef enum logic [0:0] {
    GEN_IDLE,
    GEN_RUN
  } gen_state_type;

endpackage

// [rtl/sound_amplitude_pwm.sv]
// Amplitude PWM, tone-duration counter and next-data interrupt flag.
// Assumes tone and attack/decay inputs come from logic on hclk.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps

// What this block does
// RQ1: Interrupt output is high while next-data flag and its enable are set.
// RQ2: Set next-data flag whenever configuration is copied into buffers.
// RQ3: Also set next-data flag when a reload point finds reload request clear.
// RQ4: Writing one clears the next-data flag; writing zero leaves it.
// RQ5: Each reload copies amplitude setting into read-only working amplitude.
// RQ6: Attack or decay steps only the working amplitude, never the setting.
// RQ7: Output amplitude comes only from the working amplitude register.
// RQ8: Duration counter advances once per falling edge of the tone signal.
// RQ9: Duration counter returns to zero at the falling edge that finds it at the duration length.
// RQ10: Any generator stop clears the duration counter.
// RQ11: Duration counter is readable; software writes do not change it.
// RQ12: PWM period equals one period of the divided prescaler signal.
// RQ13: Duty is amplitude over divisor plus one; saturates at 100 percent.
// RQ14: Amplitude writes affect the PWM only after the next reload.
// RQ15: Bus clock is divided by prescale divisor plus one.
// RQ16: Start with reload request set loads buffers and sets the flag.
// RQ17: One tone duration holds duration length plus one tone cycles.
// RQ18: PWM is high while prescaler count is below working amplitude.
module sound_amplitude_pwm
  import sound_pwm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Tone generator and attack/decay engine
  input wire logic tone_level,
  input wire logic ad_mode,
  input wire logic ad_step_valid,
  input wire logic [LEVEL_W-1:0] ad_step_level,
  input wire logic ad_reload_point,
  // Status towards the rest of the unit
  output logic prescale_tick,
  output logic running,
  output logic reload_pulse,
  output logic duration_done,
  output logic [LEVEL_W-1:0] amplitude_working,
  // Sound output and interrupt
  output logic pwm_out,
  output logic irq
);

  function automatic logic hit(input logic [IDX_W-1:0] a,
                               input logic [IDX_W-1:0] idx);
    hit = (a == idx);
  endfunction

  // Bus pipeline
  logic wr_pend_q;
  logic rd_pend_q;
  logic [IDX_W-1:0] addr_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic accept;
  logic wr_en;
  logic [REG_W-1:0] wbyte;

  // Software registers
  logic [REG_W-1:0] control_q;
  logic [LEVEL_W-1:0] prescale_q;
  logic [LEVEL_W-1:0] amplitude_q;
  logic [COUNT_W-1:0] duration_q;
  logic [REG_W-1:0] irq_enable_q;
  logic [REG_W-1:0] irq_enable_d;
  logic [REG_W-1:0] irq_flag_q;
  logic [REG_W-1:0] irq_flag_d;

  // Buffers and counters
  gen_state_type state_q;
  logic [LEVEL_W-1:0] prescale_buf_q;
  logic [LEVEL_W-1:0] amp_working_q;
  logic [COUNT_W-1:0] duration_buf_q;
  logic [LEVEL_W-1:0] pcount_q;
  logic [COUNT_W-1:0] dcount_q;
  logic tone_prev_q;
  logic tick_q;
  logic pwm_q;
  logic irq_q;
  logic reload_q;
  logic done_q;
  logic running_q;
  logic hresp_q;

  // Sequencing terms
  logic run_ok;
  logic tone_fall;
  logic dur_wrap;
  logic reload_point;
  logic do_load;
  logic do_stop;
  logic set_flag;

  assign addr_ok = (haddr[31:IDX_W+2] == '0) && (haddr[1:0] == 2'b00);
  assign accept = hsel && htrans[1] && hready;
  assign wr_en = wr_pend_q;
  assign wbyte = hwdata[REG_W-1:0];

  // Address phase capture; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
      hready_q <= 1'b1;
    end else begin
      wr_pend_q <= accept && hwrite;
      rd_pend_q <= accept && !hwrite;
      hready_q <= !(accept && !hwrite);
      if (accept) begin
        // Out-of-range or misaligned addresses land on the top index, read 0
        addr_q <= addr_ok ? haddr[IDX_W+1:2] : '1;
      end
    end
  end

  // Error response is never raised; kept registered like every output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  // Read data is sampled after any earlier write has landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= RDATA_RESET;
    end else if (rd_pend_q) begin
      hrdata_q <= RDATA_RESET;
      case (addr_q)
        IDX_CONTROL: begin
          hrdata_q[REG_W-1:0] <= control_q;
        end
        IDX_PRESCALE_HIGH: begin
          hrdata_q[HIGH_PART_W-1:0] <= prescale_q[LEVEL_W-1:REG_W];
        end
        IDX_PRESCALE_LOW: begin
          hrdata_q[REG_W-1:0] <= prescale_q[REG_W-1:0];
        end
        IDX_AMPLITUDE_HIGH: begin
          hrdata_q[HIGH_PART_W-1:0] <= amplitude_q[LEVEL_W-1:REG_W];
        end
        IDX_AMPLITUDE_LOW: begin
          hrdata_q[REG_W-1:0] <= amplitude_q[REG_W-1:0];
        end
        IDX_DURATION_LENGTH: begin
          hrdata_q[COUNT_W-1:0] <= duration_q;
        end
        IDX_IRQ_ENABLE: begin
          hrdata_q[REG_W-1:0] <= irq_enable_q;
        end
        IDX_IRQ_FLAG: begin
          hrdata_q[REG_W-1:0] <= irq_flag_q;
        end
        IDX_WORKING_HIGH: begin
          hrdata_q[HIGH_PART_W-1:0] <= amp_working_q[LEVEL_W-1:REG_W];
        end
        IDX_WORKING_LOW: begin
          hrdata_q[REG_W-1:0] <= amp_working_q[REG_W-1:0];
        end
        IDX_DURATION_COUNT: begin
          hrdata_q[COUNT_W-1:0] <= dcount_q; // [RQ11]
        end
        default: begin
          hrdata_q <= RDATA_RESET;
        end
      endcase
    end
  end

  // Writable configuration; working amplitude and count ignore writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_q <= CONTROL_RESET;
      prescale_q <= PRESCALE_RESET;
      amplitude_q <= AMPLITUDE_RESET;
      duration_q <= DURATION_RESET;
      irq_enable_q <= IRQ_RESET;
    end else if (wr_en) begin
      if (hit(addr_q, IDX_CONTROL)) begin
        control_q <= {5'b0_0000, wbyte[2:0]};
      end
      if (hit(addr_q, IDX_PRESCALE_HIGH)) begin
        prescale_q[LEVEL_W-1:REG_W] <= wbyte[HIGH_PART_W-1:0];
      end
      if (hit(addr_q, IDX_PRESCALE_LOW)) begin
        prescale_q[REG_W-1:0] <= wbyte;
      end
      if (hit(addr_q, IDX_AMPLITUDE_HIGH)) begin
        amplitude_q[LEVEL_W-1:REG_W] <= wbyte[HIGH_PART_W-1:0];
      end
      if (hit(addr_q, IDX_AMPLITUDE_LOW)) begin
        amplitude_q[REG_W-1:0] <= wbyte;
      end
      if (hit(addr_q, IDX_DURATION_LENGTH)) begin
        duration_q <= wbyte;
      end
      if (hit(addr_q, IDX_IRQ_ENABLE)) begin
        irq_enable_q <= {7'b000_0000, wbyte[NEXT_DATA_BIT]};
      end
    end
  end

  // Start, reload and stop decisions
  assign run_ok = control_q[CTRL_ENABLE] && !control_q[CTRL_STOP];
  // Previous sample resets low, the tone's idle level: no edge after reset
  assign tone_fall = tone_prev_q && !tone_level; // [RQ8]
  assign dur_wrap = (state_q == GEN_RUN) && tone_fall
                    && (dcount_q == duration_buf_q);
  assign reload_point = (state_q == GEN_RUN) && run_ok
                        && (ad_mode ? ad_reload_point : dur_wrap);
  always_comb begin
    do_load = 1'b0;
    do_stop = 1'b0;
    set_flag = 1'b0;
    case (state_q)
      GEN_IDLE: begin
        if (run_ok && control_q[CTRL_RELOAD_REQUEST]) begin
          do_load = 1'b1; // [RQ16]
          set_flag = 1'b1; // [RQ2]
        end
      end
      GEN_RUN: begin
        if (!run_ok) begin
          do_stop = 1'b1;
        end else if (reload_point) begin
          if (control_q[CTRL_RELOAD_REQUEST]) begin
            do_load = 1'b1;
          end else begin
            do_stop = 1'b1;
          end
          set_flag = 1'b1; // [RQ2] [RQ3]
        end
      end
      default: begin
        do_stop = 1'b1;
      end
    endcase
  end

  // Running mirrors the state so the status output comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= GEN_IDLE;
      running_q <= 1'b0;
    end else if (do_stop) begin
      state_q <= GEN_IDLE;
      running_q <= 1'b0;
    end else if (do_load) begin
      state_q <= GEN_RUN;
      running_q <= 1'b1;
    end
  end

  // Buffers load only at reload; setting stays untouched by steps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_buf_q <= PRESCALE_RESET;
      duration_buf_q <= DURATION_RESET;
      amp_working_q <= AMPLITUDE_RESET;
    end else if (do_load) begin
      prescale_buf_q <= prescale_q;
      duration_buf_q <= duration_q;
      amp_working_q <= amplitude_q; // [RQ5] [RQ14]
      // A load outranks a same-cycle step so the new setting is not lost
    end else if ((state_q == GEN_RUN) && ad_mode && ad_step_valid) begin
      amp_working_q <= ad_step_level; // [RQ6]
    end
  end

  // Prescaler: wraps after divisor plus one cycles
  // Every load restarts the count, so the first period is a full one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcount_q <= '0;
      tick_q <= 1'b0;
    end else if ((state_q != GEN_RUN) || do_stop || do_load) begin
      pcount_q <= '0;
      tick_q <= 1'b0;
    end else if (pcount_q == prescale_buf_q) begin
      pcount_q <= '0; // [RQ15]
      tick_q <= 1'b1;
    end else begin
      pcount_q <= pcount_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // PWM over one prescaler period; saturates when level exceeds divisor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= (state_q == GEN_RUN)
               && (pcount_q < amp_working_q); // [RQ7] [RQ12] [RQ13] [RQ18]
    end
  end

  // Duration counter on tone falling edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tone_prev_q <= 1'b0;
      dcount_q <= '0;
      done_q <= 1'b0;
    end else begin
      tone_prev_q <= tone_level;
      done_q <= dur_wrap && run_ok;
      if ((state_q != GEN_RUN) || do_stop || do_load) begin
        dcount_q <= '0; // [RQ10]
      end else if (dur_wrap) begin
        dcount_q <= '0; // [RQ9] [RQ17]
      end else if (tone_fall) begin
        dcount_q <= dcount_q + 1'b1; // [RQ8]
      end
    end
  end

  // Next enable, so the request follows an enable write within one edge
  always_comb begin
    irq_enable_d = irq_enable_q;
    if (wr_en && hit(addr_q, IDX_IRQ_ENABLE)) begin
      irq_enable_d = {7'b000_0000, wbyte[NEXT_DATA_BIT]};
    end
  end

  // Next-data flag: hardware set beats a same-cycle clear
  always_comb begin
    irq_flag_d = irq_flag_q;
    if (wr_en && hit(addr_q, IDX_IRQ_FLAG) && wbyte[NEXT_DATA_BIT]) begin
      irq_flag_d[NEXT_DATA_BIT] = 1'b0; // [RQ4]
    end
    if (set_flag) begin
      irq_flag_d[NEXT_DATA_BIT] = 1'b1; // [RQ2] [RQ3]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_flag_q <= IRQ_RESET;
      irq_q <= 1'b0;
      reload_q <= 1'b0;
    end else begin
      irq_flag_q <= irq_flag_d;
      irq_q <= |(irq_flag_d & irq_enable_d); // [RQ1]
      reload_q <= do_load;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = hresp_q;
  assign prescale_tick = tick_q;
  assign running = running_q;
  assign reload_pulse = reload_q;
  assign duration_done = done_q;
  assign amplitude_working = amp_working_q;
  assign pwm_out = pwm_q;
  assign irq = irq_q;

endmodule

// [sim/amp_props.sv]
// Checker: bus timing, run gating, interrupt release and PWM floor.
// Assumes it is bound to every instance of sound_amplitude_pwm.
`timescale 1ns/100ps
module amp_props
  import sound_pwm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Status
  input wire logic running,
  input wire logic reload_pulse,
  input wire logic duration_done,
  input wire logic [LEVEL_W-1:0] amplitude_working,
  input wire logic pwm_out,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic wr_take;
  assign take = hsel && htrans[1] && hready;
  assign wr_take = take && hwrite;
  a_resp_okay: assert property (!hresp)
    else $error("hresp not OKAY");
  a_write_no_wait: assert property (wr_take |=> hreadyout)
    else $error("write data phase waited");
  a_read_one_wait: assert property
    (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_reload_in_run: assert property (reload_pulse |->
    running || $past(running) || $past(running, 2))
    else $error("reload pulse while idle");
  a_done_in_run: assert property (duration_done |->
    running || $past(running) || $past(running, 2))
    else $error("duration done while idle");
  a_irq_fall_write: assert property
    ($fell(irq) |-> $past(wr_take, 2))
    else $error("irq dropped without a write");
  a_working_in_run: assert property
    (!$stable(amplitude_working) |-> running || $past(running))
    else $error("working amplitude changed while idle");
  a_pwm_zero_floor: assert property (running &&
    $past(running, 2) && $past(amplitude_working) == '0 |-> !pwm_out)
    else $error("pwm high with zero amplitude");
  c_reload: cover property (reload_pulse);
  c_irq: cover property ($rose(irq));
  c_done: cover property (duration_done);
endmodule
bind sound_amplitude_pwm amp_props u_props (.*);

// [sim/tb_top.sv]
// Bench: drives the sound block over AHB-Lite and its tone/step inputs.
// Assumes the checker file is compiled beside it.
`timescale 1ns/100ps
module tb_top
  import sound_pwm_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic tone_level, ad_mode, ad_step_valid, ad_reload_point;
  logic [LEVEL_W-1:0] ad_step_level, amplitude_working;
  logic prescale_tick, running, reload_pulse, duration_done, pwm_out, irq;
  int fails = 0;
  int checks = 0;
  int reloads = 0;
  int dones = 0;
  assign hready = hreadyout;
  sound_amplitude_pwm uut (.*);
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Pulse counts, taken where the registered pulses are settled
  always @(negedge hclk) begin
    if (reload_pulse === 1'b1) reloads++;
    if (duration_done === 1'b1) dones++;
  end
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // Registered answers: the level seen at a falling edge holds at the next rise
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    r = hrdata;
    if (hready !== 1'b1) begin
      fails++;
      print_verdict();
    end
    @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, i, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    wait_ready();
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rc(input string nm, input logic [5:0] i, input logic [31:0] e);
    bus(1'b0, i, 8'h00);
    chk(nm, e, r);
  endtask
  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (running !== v && n < 40) begin
      @(negedge hclk);
      n++;
    end
    chk("running", {31'h0, v}, {31'h0, running});
    if (running !== v) print_verdict();
  endtask
  task automatic pwm_chk(input logic [31:0] e);
    logic [31:0] h, t;
    h = '0;
    t = '0;
    repeat (16) begin
      @(negedge hclk);
      h += {31'h0, pwm_out === 1'b1};
      t += {31'h0, prescale_tick === 1'b1};
    end
    chk("pwm high", e, h);
    chk("ticks", 32'h4, t);
  endtask
  // Two cycles high, two low: one falling edge each
  task automatic tone(input int n);
    repeat (n) begin
      @(posedge hclk);
      tone_level <= 1'b1;
      repeat (2) @(posedge hclk);
      tone_level <= 1'b0;
      @(posedge hclk);
    end
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    tone_level = 1'b0;
    ad_mode = 1'b0;
    ad_step_valid = 1'b0;
    ad_step_level = '0;
    ad_reload_point = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rc("prescale lo", IDX_PRESCALE_LOW, 32'hff);
    rc("flag", IDX_IRQ_FLAG, 32'h0);
    wr(IDX_WORKING_LOW, 8'h55);
    wr(IDX_DURATION_COUNT, 8'h33);
    rc("working", IDX_WORKING_LOW, 32'h0);
    rc("count", IDX_DURATION_COUNT, 32'h0);
    wr(6'h3f, 8'h77);
    rc("unmapped", 6'h3f, 32'h0);
    // Period of four cycles, amplitude 2, two tone cycles per duration
    wr(IDX_PRESCALE_LOW, 8'h03);
    wr(IDX_PRESCALE_HIGH, 8'h00);
    wr(IDX_AMPLITUDE_LOW, 8'h02);
    wr(IDX_DURATION_LENGTH, 8'h01);
    wr(IDX_IRQ_ENABLE, 8'h01);
    wr(IDX_CONTROL, 8'h03);
    wait_run(1'b1);
    rc("working", IDX_WORKING_LOW, 32'h2);
    rc("flag", IDX_IRQ_FLAG, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    chk("reloads", 32'h1, reloads);
    pwm_chk(32'h8);
    wr(IDX_AMPLITUDE_LOW, 8'h09);
    pwm_chk(32'h8);
    wr(IDX_IRQ_FLAG, 8'h00);
    rc("flag", IDX_IRQ_FLAG, 32'h1);
    wr(IDX_IRQ_FLAG, 8'h01);
    rc("flag", IDX_IRQ_FLAG, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    tone(1);
    rc("count", IDX_DURATION_COUNT, 32'h1);
    tone(1);
    rc("count", IDX_DURATION_COUNT, 32'h0);
    rc("working", IDX_WORKING_LOW, 32'h9);
    rc("flag", IDX_IRQ_FLAG, 32'h1);
    chk("reloads", 32'h2, reloads);
    chk("dones", 32'h1, dones);
    pwm_chk(32'h10);
    // Masked interrupt, then stop at a reload point with no request
    wr(IDX_IRQ_FLAG, 8'h01);
    wr(IDX_IRQ_ENABLE, 8'h00);
    wr(IDX_CONTROL, 8'h02);
    tone(2);
    wait_run(1'b0);
    rc("flag", IDX_IRQ_FLAG, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    rc("count", IDX_DURATION_COUNT, 32'h0);
    chk("reloads", 32'h2, reloads);
    chk("dones", 32'h2, dones);
    wr(IDX_IRQ_ENABLE, 8'h01);
    repeat (2) @(negedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    // Stop bit in mid-duration
    wr(IDX_IRQ_FLAG, 8'h01);
    wr(IDX_CONTROL, 8'h03);
    wait_run(1'b1);
    tone(1);
    rc("count", IDX_DURATION_COUNT, 32'h1);
    wr(IDX_CONTROL, 8'h07);
    wait_run(1'b0);
    rc("count", IDX_DURATION_COUNT, 32'h0);
    // Attack/decay steps the working value only
    @(posedge hclk);
    ad_mode <= 1'b1;
    ad_step_level <= 11'h001;
    wr(IDX_CONTROL, 8'h03);
    wait_run(1'b1);
    @(posedge hclk);
    ad_step_valid <= 1'b1;
    @(posedge hclk);
    ad_step_valid <= 1'b0;
    rc("working", IDX_WORKING_LOW, 32'h1);
    rc("setting", IDX_AMPLITUDE_LOW, 32'h9);
    pwm_chk(32'h4);
    @(posedge hclk);
    ad_reload_point <= 1'b1;
    @(posedge hclk);
    ad_reload_point <= 1'b0;
    rc("working", IDX_WORKING_LOW, 32'h9);
    chk("working port", 32'h9, {21'h0, amplitude_working});
    @(posedge hclk);
    ad_step_level <= 11'h000;
    ad_step_valid <= 1'b1;
    @(posedge hclk);
    ad_step_valid <= 1'b0;
    @(posedge hclk);
    chk("working port", 32'h0, {21'h0, amplitude_working});
    pwm_chk(32'h0);
    // Clearing the enable also stops the generator and its counters
    wr(IDX_CONTROL, 8'h01);
    wait_run(1'b0);
    rc("count", IDX_DURATION_COUNT, 32'h0);
    chk("reloads", 32'h5, reloads);
    chk("dones", 32'h2, dones);
    print_verdict();
  end
endmodule
